// ---- design/tus_top.sv ----
`timescale 1ns/1ns
module tus_top
  import tus_pkg::*;
#(
  parameter int HOLD_DEF = HOLD_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire tus_xport_t xport,
  input wire tus_fmt_in_t fmt,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output tus_stat_t stat
);

  //------------------------------------------------------------
  // Declarations
  //------------------------------------------------------------
  tus_stat_t stat_ff, nxt_stat;
  logic [HOLD_W-1:0] hold_cnt_ff, nxt_hold_cnt;
  logic loaded_d_ff, nxt_loaded_d;
  logic reu_d_ff, nxt_reu_d;
  logic [HOLD_W-1:0] hold_limit;
  logic force_offline;
  logic power_reset;
  logic online_gate;
  logic lol_cmd;
  logic reu_cmd;
  logic hold_run;
  logic hold_done;
  logic online_clr;

  //------------------------------------------------------------
  // Register bus
  //------------------------------------------------------------
  tus_apb_regs #(
    .HOLD_DEF(HOLD_DEF)
  ) u_regs (
    .clk(clk),
    .srst(srst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .stat(stat_ff),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .hold_limit(hold_limit),
    .force_offline(force_offline)
  );

  //------------------------------------------------------------
  // Command qualification
  //------------------------------------------------------------
  // R15 power reset
  // Power reset combines the reset input with a sensed power failure.
  assign power_reset = srst | xport.power_fail;
  // R19 select online gate
  // Rewind-unload and accept are gated with select and the online state.
  assign online_gate = fmt.select & stat_ff.online_state;
  assign reu_cmd = online_gate & fmt.if_rewind_unload_cmd;
  // The load command is gated by select only, else an offline unit never loads.
  assign lol_cmd = fmt.select & fmt.if_load_online_cmd;

  //------------------------------------------------------------
  // Load fault timer
  //------------------------------------------------------------
  // R12 interlock hold timer
  // The timer runs while a load has tape in the columns with the interlock open.
  always_comb begin
    hold_run = xport.loading & xport.in_columns & ~xport.interlock;
    hold_done = hold_run & (hold_cnt_ff >= hold_limit - HOLD_W'(1));
    nxt_hold_cnt = hold_cnt_ff;
    if (power_reset | ~hold_run) begin
      nxt_hold_cnt = '0;
    end else if (~hold_done) begin
      nxt_hold_cnt = hold_cnt_ff + HOLD_W'(1);
    end
  end

  // Timer register.
  always_ff @(posedge clk) begin
    if (srst) begin
      hold_cnt_ff <= '0;
    end else begin
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  //------------------------------------------------------------
  // Qualified state
  //------------------------------------------------------------
  // Next values of every status flip-flop and the two edge delays; the timer is done above.
  always_comb begin
    nxt_stat = stat_ff;
    nxt_loaded_d = xport.tape_loaded;
    nxt_reu_d = reu_cmd;
    online_clr = xport.panel_reset | stat_ff.rewind_unload_request | force_offline;
    // R16 panel reset select
    nxt_stat.select_state = fmt.select & ~xport.panel_reset;
    // R1 start marker qualify
    nxt_stat.start_marker_qualified = xport.start_marker_raw & ~xport.rewinding & ~xport.loading
      & ~xport.end_marker_raw;
    // R2 end marker qualify
    nxt_stat.end_marker_qualified = xport.end_marker_raw & ~xport.rewinding & ~xport.start_marker_raw;
    // R5 ready from loaded
    nxt_stat.ready = xport.tape_loaded & ~xport.rewinding;
    // R3 forward enable gating
    nxt_stat.forward_enable = fmt.select & nxt_stat.ready & stat_ff.online_state;
    // R4 motion from commands
    nxt_stat.motion = fmt.fwd_cmd | fmt.rev_cmd;
    // R6 combined ready indications
    nxt_stat.ready_offline = nxt_stat.ready & ~stat_ff.online_state;
    nxt_stat.ready_online = nxt_stat.ready & stat_ff.online_state;
    // R7 accept command indication
    nxt_stat.accept_command = online_gate & nxt_stat.ready;
    // R9 strobe sets online
    // The strobe set wins over a panel reset, rewind request or forced offline in the same cycle; a power reset still clears it.
    nxt_stat.online_state = stat_ff.load_complete_strobe | (stat_ff.online_state & ~online_clr);
    // R9 load completion strobe
    nxt_stat.load_complete_strobe = stat_ff.load_online_state & xport.tape_loaded & ~xport.rewinding
      & ~stat_ff.load_complete_strobe;
    // R10 load online set
    // A new command wins over the end of a previous operation.
    nxt_stat.load_online_state = lol_cmd
      | (stat_ff.load_online_state & ~stat_ff.load_complete_strobe & ~stat_ff.load_abort);
    // R11 loaded once set
    nxt_stat.loaded_once = stat_ff.loaded_once | (xport.tape_loaded & ~loaded_d_ff);
    // R12 load abort level
    // Abort stays up until the transport drops its load sequence.
    nxt_stat.load_abort = hold_done | (stat_ff.load_abort & xport.loading);
    // R13 rewind unload pulse
    // R8 commands need online
    nxt_stat.rewind_unload_request = reu_cmd & ~reu_d_ff;
    // R14 high density select
    nxt_stat.high_density_sel = xport.panel_density | fmt.if_density_select;
    // R20 select status gate
    nxt_stat.if_end_marker_status = fmt.select & nxt_stat.end_marker_qualified;
    nxt_stat.if_density_status = fmt.select & nxt_stat.high_density_sel;
    nxt_stat.if_online_status = fmt.select & nxt_stat.online_state;
    // R15 power reset clear
    if (power_reset) begin
      nxt_stat = '0;
      nxt_loaded_d = 1'b0;
      nxt_reu_d = 1'b0;
    end
  end

  // R21 synchronous state register
  // All state registers here on the one clock.
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_ff <= '0;
      loaded_d_ff <= 1'b0;
      reu_d_ff <= 1'b0;
    end else begin
      stat_ff <= nxt_stat;
      loaded_d_ff <= nxt_loaded_d;
      reu_d_ff <= nxt_reu_d;
    end
  end

  assign stat = stat_ff;

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  start_marker_a: assert property ( // R1
    stat.start_marker_qualified |-> $past(xport.start_marker_raw & ~xport.rewinding & ~xport.loading
      & ~xport.end_marker_raw))
    else $error("Start marker raised while suppressed.");

  end_marker_a: assert property ( // R2
    $past(xport.end_marker_raw & ~xport.rewinding & ~xport.start_marker_raw & ~xport.power_fail)
      |-> stat.end_marker_qualified)
    else $error("End marker missed.");

  forward_gate_a: assert property ( // R3
    stat.forward_enable |-> $past(fmt.select & xport.tape_loaded & ~xport.rewinding))
    else $error("Forward enable without select and ready.");

  motion_level_a: assert property ( // R4
    $past(~xport.power_fail) |-> (stat.motion == $past(fmt.fwd_cmd | fmt.rev_cmd)))
    else $error("Motion does not follow commands.");

  ready_pair_a: assert property ( // R6
    !(stat.ready_offline && stat.ready_online) && ((stat.ready_offline | stat.ready_online) == stat.ready))
    else $error("Ready indications inconsistent.");

  accept_cmd_a: assert property ( // R7
    stat.accept_command |-> stat.ready && $past(fmt.select))
    else $error("Accept command without ready and select.");

  online_set_a: assert property ( // R9
    stat.load_complete_strobe && !xport.power_fail |=> stat.online_state)
    else $error("Load strobe did not set online.");

  strobe_pulse_a: assert property ( // R9
    stat.load_complete_strobe |=> !stat.load_complete_strobe ##1 !stat.load_online_state || $past(lol_cmd))
    else $error("Load strobe longer than one cycle.");

  online_rise_a: assert property ( // R9
    $rose(stat.online_state) |-> $past(stat.load_complete_strobe))
    else $error("Online set without load strobe.");

  reu_gate_a: assert property ( // R13
    stat.rewind_unload_request |-> $past(online_gate & fmt.if_rewind_unload_cmd))
    else $error("Rewind request without qualified command.");

  power_clear_a: assert property ( // R15
    xport.power_fail |=> (stat == '0))
    else $error("Power failure did not clear state.");

  panel_reset_a: assert property ( // R16
    xport.panel_reset |=> !stat.select_state && (!stat.online_state || $past(stat.load_complete_strobe)))
    else $error("Panel reset left selected state.");

  status_gate_a: assert property ( // R20
    (stat.if_end_marker_status | stat.if_density_status | stat.if_online_status) |-> $past(fmt.select))
    else $error("Status driven while not selected.");

  density_sel_a: assert property ( // R14
    $past(~xport.power_fail & (xport.panel_density | fmt.if_density_select)) |-> stat.high_density_sel)
    else $error("High density not selected.");

  online_cov_c: cover property ($rose(stat.online_state));
  abort_cov_c: cover property ($rose(stat.load_abort));
  reu_cov_c: cover property (stat.rewind_unload_request ##1 !stat.online_state);
  read_cov_c: cover property (psel && penable && pready && !pwrite);

endmodule : tus_top

// ---- common/tus_pkg.sv ----
//------------------------------------------------------------
// Function
// R1 - Start marker only when idle, no end
// R2 - End marker except rewind or start tab
// R3 - Forward enable needs selected, ready, online
// R4 - Motion follows forward or reverse command
// R5 - Ready means loaded and not rewinding
// R6 - Ready offline and ready online indications
// R7 - Accept command when online, ready, selected
// R8 - Online flip-flop gates interface commands; here only rewind unload is gated, not load online or density
// R9 - Load completion strobe sets online
// R10 - Load online command sets load flip-flop
// R11 - Loaded once set after load finishes
// R12 - Load abort when interlock stays open
// R13 - Rewind unload request from interface command
// R14 - High density from panel or interface
// R15 - Power on or failure resets logic
// R16 - Panel reset clears selected flip-flops
// R17 - Formatter strobes write data into unit; no data path is built here
// R18 - Formatter takes read data on strobe; no data path is built here
// R19 - Commands qualified by select and online; here load online needs select only, fwd, rev and density select neither
// R20 - Status outputs gated by select
// R21 - One clock, synchronous reset of state
//------------------------------------------------------------
package tus_pkg;

  // Register byte offsets and fields.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h04;
  localparam int HOLD_W = 20;
  localparam int CTRL_HOLD_LSB = 0;
  localparam int CTRL_OFFL_BIT = 20;

  // Interlock hold time before a load is aborted.
  localparam int HOLD_TIME_US = 1000;
  localparam int CLK_MHZ = 250;
  localparam int HOLD_CYC = HOLD_TIME_US * CLK_MHZ;

  // Signals sensed from the transport and the front panel.
  typedef struct packed {
    logic start_marker_raw;
    logic end_marker_raw;
    logic rewinding;
    logic loading;
    logic tape_loaded;
    logic in_columns;
    logic interlock;
    logic power_fail;
    logic panel_reset;
    logic panel_density;
  } tus_xport_t;

  // Lines driven by the formatter.
  typedef struct packed {
    logic select;
    logic fwd_cmd;
    logic rev_cmd;
    logic if_load_online_cmd;
    logic if_rewind_unload_cmd;
    logic if_density_select;
  } tus_fmt_in_t;

  // Qualified state and status, also read back as the status word.
  typedef struct packed {
    logic select_state;
    logic start_marker_qualified;
    logic end_marker_qualified;
    logic forward_enable;
    logic motion;
    logic ready;
    logic ready_offline;
    logic ready_online;
    logic accept_command;
    logic online_state;
    logic load_online_state;
    logic load_complete_strobe;
    logic loaded_once;
    logic load_abort;
    logic rewind_unload_request;
    logic high_density_sel;
    logic if_end_marker_status;
    logic if_density_status;
    logic if_online_status;
  } tus_stat_t;

  localparam int STAT_W = $bits(tus_stat_t);

endpackage : tus_pkg

// ---- design/tus_apb_regs.sv ----
`timescale 1ns/1ns
module tus_apb_regs
  import tus_pkg::*;
#(
  parameter int HOLD_DEF = HOLD_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire tus_stat_t stat,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [HOLD_W-1:0] hold_limit,
  output logic force_offline
);

  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [HOLD_W-1:0] hold_ff, nxt_hold;
  logic offl_ff, nxt_offl;
  logic acc;
  logic hit_ctrl;
  logic hit_stat;
  logic done;

  // Access phase answered one cycle later; the control word is written when pready is seen high.
  always_comb begin
    acc = psel & penable & ~pready_ff;
    done = psel & penable & pready_ff;
    hit_ctrl = (paddr == REG_CTRL);
    hit_stat = (paddr == REG_STAT);
    nxt_pready = acc;
    nxt_pslverr = acc & ~(hit_ctrl | hit_stat | 1'b0) | (acc & pwrite & hit_stat);
    nxt_prdata = 32'h0000_0000;
    nxt_hold = hold_ff;
    nxt_offl = offl_ff;
    if (acc & ~pwrite & hit_ctrl) begin
      nxt_prdata[CTRL_HOLD_LSB +: HOLD_W] = hold_ff;
      nxt_prdata[CTRL_OFFL_BIT] = offl_ff;
    end
    if (acc & ~pwrite & hit_stat) begin
      nxt_prdata[STAT_W-1:0] = stat;
    end
    if (done & pwrite & hit_ctrl) begin
      nxt_hold = pwdata[CTRL_HOLD_LSB +: HOLD_W];
      nxt_offl = pwdata[CTRL_OFFL_BIT];
    end
  end

  // Bus answer and control registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      hold_ff <= HOLD_W'(HOLD_DEF);
      offl_ff <= 1'b0;
    end else begin
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      hold_ff <= nxt_hold;
      offl_ff <= nxt_offl;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign hold_limit = hold_ff;
  assign force_offline = offl_ff;

endmodule : tus_apb_regs

// ---- verif/tus_fmt_model.sv ----
`timescale 1ns/1ns
module tus_fmt_model
  import tus_pkg::*;
(
  input wire logic clk,
  input wire tus_stat_t stat,
  output tus_fmt_in_t fmt
);
  //----------------------------------------
  // Formatter command lines
  //----------------------------------------
  // All lines idle at power up, so no command is seen during reset.
  initial begin
    fmt = '0;
  end

  // strobe timing kept
  // Lines change only just after an edge and then stand until the next call.
  // The data strobes are not modelled, since this block has no data path.
  task put(input tus_fmt_in_t v);
    @(posedge clk);
    fmt <= v;
  endtask : put
endmodule : tus_fmt_model

// ---- verif/tus_top_tb.sv ----
`timescale 1ns/1ns
module tus_top_tb
  import tus_pkg::*;
;
  localparam int HOLD_SIM = 20;
  logic clk;
  logic srst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  tus_xport_t xport;
  tus_fmt_in_t fmt;
  tus_stat_t stat;
  int fail_count;
  int checks;
  int n;
  logic [9:0] mk [6] = '{10'h208, 10'h288, 10'h248, 10'h308, 10'h108, 10'h188};
  logic [1:0] me [6] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0};
  logic [5:0] mv [4] = '{6'h10, 6'h08, 6'h18, 6'h00};

  tus_top #(.HOLD_DEF(HOLD_SIM)) u_dut (.clk(clk), .srst(srst), .xport(xport), .fmt(fmt),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .stat(stat));
  tus_fmt_model u_fmt (.clk(clk), .stat(stat), .fmt(fmt));

  //----------------------------------------
  // Helpers
  //----------------------------------------
  // The clock toggles every 2 ns for a 4 ns period.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A hung run is cut short here and counted as a mismatch.
  initial begin
    #100000;
    fail_count++;
    summarize();
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task summarize();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // Lets the registered picture catch up with held inputs.
  task settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle

  task xset(input tus_xport_t v);
    @(posedge clk);
    xport <= v;
  endtask : xset

  // One APB transfer; the request stands until pready is sampled high or 20 cycles pass.
  task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Remote load and on line, walked cycle by cycle.
  task do_load();
    u_fmt.put(6'h24);
    u_fmt.put(6'h20);
    #1;
    chk("lol_ff", 1, stat.load_online_state);
    @(posedge clk);
    #1;
    chk("lol_strobe", 1, stat.load_complete_strobe);
    chk("loaded_once", 1, stat.loaded_once);
    @(posedge clk);
    #1;
    chk("online", 1, stat.online_state);
    chk("lol_clear", 0, stat.load_online_state);
  endtask : do_load

  //----------------------------------------
  // Main sequence
  //----------------------------------------
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    xport = 10'h008;
    fail_count = 0;
    checks = 0;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_rst", HOLD_SIM, rd);
    apb(1'b0, REG_STAT, 32'h0);
    chk("stat_rst", 0, rd);
    apb(1'b0, 8'hFB, 32'h0);
    chk("unmapped", 1, err);
    apb(1'b1, REG_STAT, 32'h1);
    chk("stat_ro", 1, err);
    for (int i = 0; i < 6; i++) begin
      xset(mk[i]);
      settle();
      chk("start_q", me[i][1], stat.start_marker_qualified);
      chk("end_q", me[i][0], stat.end_marker_qualified);
    end
    for (int i = 0; i < 4; i++) begin
      u_fmt.put(mv[i]);
      settle();
      chk("motion", i < 3, stat.motion);
    end
    xset(10'h0A8);
    settle();
    chk("ready_rew", 0, stat.ready);
    chk("rdy_off_rew", 0, stat.ready_offline);
    xset(10'h028);
    settle();
    chk("ready", 1, stat.ready);
    chk("rdy_off", 1, stat.ready_offline);
    chk("rdy_on_off", 0, stat.ready_online);
    u_fmt.put(6'h04);
    settle();
    chk("lol_nosel", 0, stat.load_online_state);
    u_fmt.put(6'h20);
    settle();
    do_load();
    settle();
    chk("fwd_en", 1, stat.forward_enable);
    chk("accept", 1, stat.accept_command);
    chk("rdy_on", 1, stat.ready_online);
    chk("if_online", 1, stat.if_online_status);
    u_fmt.put(6'h02);
    settle();
    chk("fwd_nosel", 0, stat.forward_enable);
    chk("acc_nosel", 0, stat.accept_command);
    chk("ifonl_nosel", 0, stat.if_online_status);
    chk("online_kept", 1, stat.online_state);
    u_fmt.put(6'h20);
    settle();
    u_fmt.put(6'h22);
    u_fmt.put(6'h20);
    #1;
    chk("reu_req", 1, stat.rewind_unload_request);
    @(posedge clk);
    #1;
    chk("reu_pulse", 0, stat.rewind_unload_request);
    settle();
    chk("reu_offline", 0, stat.online_state);
    do_load();
    xset(10'h02A);
    settle();
    chk("sel_panel", 0, stat.select_state);
    chk("onl_panel", 0, stat.online_state);
    xset(10'h028);
    u_fmt.put(6'h00);
    xset(10'h029);
    settle();
    chk("hid_panel", 1, stat.high_density_sel);
    chk("if_density_status_nosel", 0, stat.if_density_status);
    xset(10'h028);
    u_fmt.put(6'h21);
    settle();
    chk("hid_if", 1, stat.high_density_sel);
    chk("if_density_status_sel", 1, stat.if_density_status);
    u_fmt.put(6'h20);
    xset(10'h128);
    settle();
    chk("if_end_marker_status_sel", 1, stat.if_end_marker_status);
    apb(1'b1, REG_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_ones", 32'h001F_FFFF, rd);
    do_load();
    settle();
    chk("onl_forced", 0, stat.online_state);
    apb(1'b1, REG_CTRL, 32'h5);
    apb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl_wr", 32'h5, rd);
    xset(10'h050);
    repeat (3) @(posedge clk);
    #1;
    chk("abort_early", 0, stat.load_abort);
    n = 0;
    while (stat.load_abort !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("abort", 1, stat.load_abort);
    xset(10'h02C);
    settle();
    chk("stat_pfail", 0, stat);
    summarize();
  end
endmodule : tus_top_tb
